// file: logic/uac_pkg.sv
// Shared constants for the UART ancillary strap, clock-routing and reset block.
// Assumes a single 25 MHz system clock.
package uac_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned RESET_MIN_NS = 40;
    localparam int unsigned RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MCR_IR_BIT = 6;
    localparam int unsigned BAUD_DIV_W = 16;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0001;
    localparam logic TX_IDLE_NORMAL = 1'b1;
    localparam logic TX_IDLE_IR = 1'b0;
    localparam logic GP_OUT_RST = 1'b1;
    localparam logic BUS_DRIVE_DISABLE_N_RST = 1'b1;
    localparam logic BAUD_OUT_RST = 1'b1;
    typedef enum logic [2:0] {
        UAC_BUS_SEP = 3'b001,
        UAC_BUS_COMB = 3'b010,
        UAC_BUS_PC = 3'b100
    } uac_bus_e;
endpackage

// file: logic/uac_sync2.sv
// Two-flip-flop synchroniser for asynchronous pin levels.
// Assumes the destination clock is i_clk; reset value is a constant parameter.
module uac_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= i_d;
            sync_ff <= meta_ff;
        end
    end

    assign o_q = sync_ff;
endmodule

// file: logic/uac_top.sv
// UART ancillary logic: bus-type straps, reset polarity, baud clock routing,
// read transceiver control, infrared strap capture and general outputs.
// Assumes pins are asynchronous to i_clk; the serial engine sits outside.
import uac_pkg::*;

// Function
// [RULE1] Receiver 16x clock from receiver clock pin
// [RULE2] Baud output active low, 16x baud clock
// [RULE3] Board ties baud output to receiver clock
// [RULE4] PC mode: internal routing, pin decodes printer
// [RULE5] Low PC select enables on-chip decode
// [RULE6] Drive disable low during host reads
// [RULE7] Capture infrared strap at reset release
// [RULE8] Transmit idles low infrared, high normal
// [RULE9] Software infrared bit overrides strap afterwards
// [RULE10] Minimum reset pulse resets registers and outputs
// [RULE11] In reset ignore receive, hold transmit high; code holds it low when the infrared strap is set
// [RULE12] Reset polarity follows bus-type select
// [RULE13] Bus-type select picks strobe bus style
// [RULE14] Two active-low general outputs from software bits
// [RULE15] PC mode only when both selects low
// [RULE16] Reset release synchronised to internal clock
module uac_top #(
    parameter int DIV_W = uac_pkg::BAUD_DIV_W
) (
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Strap and reset pins
    input wire logic i_reset_pin,
    input wire logic i_bus_type_sel,
    input wire logic i_pc_decode_sel_n,
    input wire logic i_infrared_strap,
    // Host bus strobes
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic i_cs_n,
    input wire logic i_rd_wr_n,
    // Printer port decode from the address decoder
    input wire logic i_printer_port_a_decode,
    // Receiver clock pin and serial lines
    input wire logic i_rclk,
    input wire logic i_rx,
    input wire logic i_tx_data,
    input wire logic i_tx_active,
    // Register values from the register file
    input wire logic [DIV_W-1:0] i_baud_div,
    input wire logic [7:0] i_modem_control_reg,
    input wire logic i_mcr_wr,
    input wire logic i_gp_a_bit,
    input wire logic i_gp_b_bit,
    // Clock and serial outputs
    output logic o_baud_clk_out_n,
    output logic o_rx_clk16,
    output logic o_rx_data,
    output logic o_tx,
    // Bus and mode outputs
    output logic o_bus_drive_disable_n,
    output logic o_pc_decode_en,
    output logic o_bus_sep,
    output logic o_bus_comb,
    output logic o_infrared_mode,
    output logic o_core_rst_b,
    // General-purpose outputs
    output logic o_gp_out_a_n,
    output logic o_gp_out_b_n
);
    import uac_pkg::*;

    logic [2:0] strap_s;
    logic [6:0] pin_s;
    logic bus_type_s;
    logic pc_sel_n_s;
    logic ir_strap_s;
    logic rd_n_s;
    logic cs_n_s;
    logic rd_wr_n_s;
    logic rclk_s;
    logic rx_s;
    logic reset_pin_s;

    uac_sync2 #(.W(3), .RST_VAL(3'h6)) u_sync_strap (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_d({i_bus_type_sel, i_pc_decode_sel_n, i_infrared_strap}),
        .o_q(strap_s)
    );

    uac_sync2 #(.W(7), .RST_VAL(7'h3f)) u_sync_pins (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_d({i_reset_pin, i_read_strobe_n, i_cs_n, i_rd_wr_n, i_rx, i_rclk,
              i_write_strobe_n}),
        .o_q(pin_s)
    );

    assign bus_type_s = strap_s[2];
    assign pc_sel_n_s = strap_s[1];
    assign ir_strap_s = strap_s[0];
    assign reset_pin_s = pin_s[6];
    assign rd_n_s = pin_s[5];
    assign cs_n_s = pin_s[4];
    assign rd_wr_n_s = pin_s[3];
    assign rx_s = pin_s[2];
    assign rclk_s = pin_s[1];

    // Bus mode decode
    uac_bus_e bus_mode;
    logic pc_mode;
    assign pc_mode = !bus_type_s && !pc_sel_n_s; // [RULE15] [RULE5]
    assign bus_mode = pc_mode ? UAC_BUS_PC :
        (bus_type_s ? UAC_BUS_COMB : UAC_BUS_SEP); // [RULE13] [RULE15]

    // Reset polarity: high-active with bus-type select low (separate-strobe and PC), low-active on combined-strobe bus
    logic pin_reset_active;
    assign pin_reset_active = bus_type_s ? !reset_pin_s : reset_pin_s; // [RULE12]

    // Internal reset, released on one clock edge
    logic rst_hold_ff;
    logic nxt_rst_hold;
    logic rst_dly_ff;
    assign nxt_rst_hold = pin_reset_active; // [RULE10]

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_hold_ff <= 1'b1;
            rst_dly_ff <= 1'b1;
        end else begin
            rst_hold_ff <= nxt_rst_hold; // [RULE16]
            rst_dly_ff <= rst_hold_ff;
        end
    end

    logic release_edge;
    assign release_edge = rst_dly_ff && !rst_hold_ff; // [RULE16]

    // Infrared mode: strap at release, then software bit
    logic ir_mode_ff;
    logic nxt_ir_mode;
    logic ir_strap_ff;
    assign nxt_ir_mode = rst_hold_ff ? ir_strap_s :
        release_edge ? ir_strap_s : // [RULE7]
        i_mcr_wr ? i_modem_control_reg[MCR_IR_BIT] : ir_mode_ff; // [RULE9]

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ir_mode_ff <= 1'b0;
            ir_strap_ff <= 1'b0;
        end else begin
            ir_mode_ff <= nxt_ir_mode;
            ir_strap_ff <= ir_strap_s;
        end
    end

    // Baud generator: 16x clock from the programmed divisor
    logic [DIV_W-1:0] div_cnt_ff;
    logic [DIV_W-1:0] nxt_div_cnt;
    logic baud_ff;
    logic nxt_baud;
    logic [DIV_W-1:0] div_half;
    logic div_wrap;
    assign div_half = (i_baud_div >> 1) == '0 ? DIV_W'(1) : (i_baud_div >> 1);
    assign div_wrap = div_cnt_ff >= div_half - DIV_W'(1);
    assign nxt_div_cnt = (rst_hold_ff || div_wrap) ? '0 : div_cnt_ff + DIV_W'(1);
    assign nxt_baud = rst_hold_ff ? 1'b0 : (div_wrap ? !baud_ff : baud_ff); // [RULE2]

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_ff <= '0;
            baud_ff <= 1'b0;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
            baud_ff <= nxt_baud;
        end
    end

    // Output selection
    logic nxt_baud_pin_n;
    logic nxt_rx_clk;
    logic nxt_rx_data;
    logic nxt_tx;
    logic nxt_bus_drive_disable_n_n;
    logic host_read;
    logic comb_read;
    logic sep_read;
    logic baud_src_n;
    logic rx_idle_level;
    logic tx_idle_level;
    logic tx_rst_level;
    logic tx_run_level;
    assign baud_src_n = pc_mode ? !i_printer_port_a_decode : !baud_ff; // [RULE4] [RULE2]
    assign nxt_baud_pin_n = rst_hold_ff ? BAUD_OUT_RST : baud_src_n;
    assign nxt_rx_clk = pc_mode ? baud_ff : rclk_s; // [RULE1] [RULE4]
    // Receive pin masked to its idle level while reset holds
    assign rx_idle_level = ir_mode_ff ? 1'b0 : 1'b1;
    assign nxt_rx_data = rst_hold_ff ? rx_idle_level : rx_s; // [RULE11]
    assign tx_idle_level = ir_mode_ff ? TX_IDLE_IR : TX_IDLE_NORMAL; // [RULE8]
    assign tx_rst_level = ir_strap_ff ? TX_IDLE_IR : TX_IDLE_NORMAL; // [RULE11]
    assign tx_run_level = i_tx_active ? i_tx_data : tx_idle_level;
    assign nxt_tx = rst_hold_ff ? tx_rst_level : tx_run_level;
    assign comb_read = !cs_n_s && rd_wr_n_s;
    assign sep_read = !rd_n_s && !cs_n_s;
    assign host_read = (bus_mode == UAC_BUS_COMB) ? comb_read : sep_read; // [RULE13]
    assign nxt_bus_drive_disable_n_n = rst_hold_ff ? BUS_DRIVE_DISABLE_N_RST : !host_read; // [RULE6]

    // Baud clock or printer decode pin
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_baud_clk_out_n <= BAUD_OUT_RST;
        end else begin
            o_baud_clk_out_n <= nxt_baud_pin_n;
        end
    end

    // Receiver sampling clock
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_clk16 <= 1'b0;
        end else begin
            o_rx_clk16 <= nxt_rx_clk;
        end
    end

    // Receive data towards the serial engine
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_data <= 1'b1;
        end else begin
            o_rx_data <= nxt_rx_data;
        end
    end

    // Transmit pin
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tx <= TX_IDLE_NORMAL;
        end else begin
            o_tx <= nxt_tx;
        end
    end

    // Transceiver direction
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_drive_disable_n <= BUS_DRIVE_DISABLE_N_RST;
        end else begin
            o_bus_drive_disable_n <= nxt_bus_drive_disable_n_n;
        end
    end

    // Mode flags
    logic nxt_pc_en;
    logic nxt_sep;
    logic nxt_comb;
    assign nxt_pc_en = bus_mode == UAC_BUS_PC; // [RULE5]
    assign nxt_sep = bus_mode == UAC_BUS_SEP; // [RULE13]
    assign nxt_comb = bus_mode == UAC_BUS_COMB; // [RULE13]

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pc_decode_en <= 1'b0;
            o_bus_sep <= 1'b0;
            o_bus_comb <= 1'b0;
        end else begin
            o_pc_decode_en <= nxt_pc_en;
            o_bus_sep <= nxt_sep;
            o_bus_comb <= nxt_comb;
        end
    end

    // Infrared flag and core reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_infrared_mode <= 1'b0;
            o_core_rst_b <= 1'b0;
        end else begin
            o_infrared_mode <= ir_mode_ff;
            o_core_rst_b <= !rst_hold_ff; // [RULE10]
        end
    end

    // General outputs: one flop per software bit
    logic [1:0] gp_bit;
    logic gp_n_ff [2];
    assign gp_bit = {i_gp_b_bit, i_gp_a_bit};

    for (genvar g = 0; g < 2; g++) begin : g_gp
        logic nxt_gp_n;
        assign nxt_gp_n = rst_hold_ff ? GP_OUT_RST : !gp_bit[g]; // [RULE14]

        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                gp_n_ff[g] <= GP_OUT_RST;
            end else begin
                gp_n_ff[g] <= nxt_gp_n;
            end
        end
    end

    assign o_gp_out_a_n = gp_n_ff[0];
    assign o_gp_out_b_n = gp_n_ff[1];
endmodule

// file: dv/uac_top_props.sv
// Port-level checks of the ancillary strap, reset and clock-routing block.
// Assumes binding to uac_top; straps pass two sync flops and one output flop.
module uac_top_props (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_reset_pin,
    input wire logic i_bus_type_sel,
    input wire logic i_pc_decode_sel_n,
    input wire logic i_cs_n,
    input wire logic i_read_strobe_n,
    input wire logic i_printer_port_a_decode,
    input wire logic i_tx_active,
    input wire logic i_gp_a_bit,
    input wire logic o_baud_clk_out_n,
    input wire logic o_tx,
    input wire logic o_bus_drive_disable_n,
    input wire logic o_pc_decode_en,
    input wire logic o_bus_sep,
    input wire logic o_bus_comb,
    input wire logic o_infrared_mode,
    input wire logic o_core_rst_b,
    input wire logic o_gp_out_a_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    rst_pol_a: assert property (
        (!i_bus_type_sel && i_reset_pin)[*5] |-> !o_core_rst_b) else $error("reset not taken");
    comb_mode_a: assert property (
        i_bus_type_sel[*5] |-> o_bus_comb && !o_pc_decode_en) else $error("bus style wrong");
    pc_mode_a: assert property (
        (!i_bus_type_sel && !i_pc_decode_sel_n)[*5] |-> o_pc_decode_en && !o_bus_sep)
        else $error("pc mode wrong");
    bus_drive_disable_n_low_a: assert property (
        (!i_cs_n && !i_read_strobe_n && o_bus_sep && o_core_rst_b)[*5]
        |-> !o_bus_drive_disable_n) else $error("drive disable high in read");
    bus_drive_disable_n_high_a: assert property (
        i_cs_n[*5] |-> o_bus_drive_disable_n) else $error("drive disable low");
    gp_out_a: assert property (
        o_core_rst_b && $past(o_core_rst_b) |-> o_gp_out_a_n == !$past(i_gp_a_bit))
        else $error("gp output wrong");
    tx_idle_a: assert property (
        (o_core_rst_b && !i_tx_active && !o_infrared_mode)[*2] |-> o_tx)
        else $error("tx idle not high");
    baud_pc_a: assert property (
        (o_pc_decode_en && o_core_rst_b && $stable(i_printer_port_a_decode))[*2]
        |-> o_baud_clk_out_n == !i_printer_port_a_decode) else $error("printer decode wrong");
endmodule
bind uac_top uac_top_props u_props (.*);

// file: dv/uac_host.sv
// Host model: one read cycle on the separate-strobe bus per go pulse.
// Assumes go is a one-cycle pulse from the bench.
module uac_host (
    input wire logic i_clk,
    input wire logic i_go,
    output logic o_cs_n,
    output logic o_read_strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_ff = 3'h0;
    always @(posedge i_clk) cnt_ff <= i_go ? 3'h7 : cnt_ff - 3'(cnt_ff != 3'h0);
    // Select and strobe held together for the whole cycle
    assign o_cs_n = (cnt_ff == 3'h0);
    assign o_read_strobe_n = (cnt_ff == 3'h0);
endmodule

// file: dv/uac_top_tb.sv
// Self-checking bench for uac_top.
// Assumes a 25 MHz clock; the host model drives the read strobes.
module uac_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, rpin, bsel, pcn, irs, go, ppd, txa, mwr, ga, gb, rx;
    logic [15:0] div;
    logic [7:0] modem_control_reg;
    logic cs_n, rdn, baud_n, tx, bus_drive_disable_n_n, pce, sep, comb, irm, crst, oa, ob, rxc, rxd;
    int errors = 0;
    int checks = 0;
    uac_host u_uac_host (.i_clk(clk), .i_go(go), .o_cs_n(cs_n), .o_read_strobe_n(rdn));
    uac_top u_uac_top (.i_clk(clk), .i_rst_b(rst_b), .i_reset_pin(rpin), .i_bus_type_sel(bsel),
        .i_pc_decode_sel_n(pcn), .i_infrared_strap(irs), .i_read_strobe_n(rdn),
        .i_write_strobe_n(1'b1), .i_cs_n(cs_n), .i_rd_wr_n(1'b1),
        .i_printer_port_a_decode(ppd), .i_rclk(baud_n), .i_rx(rx), .i_tx_data(ga),
        .i_tx_active(txa), .i_baud_div(div), .i_modem_control_reg(modem_control_reg), .i_mcr_wr(mwr),
        .i_gp_a_bit(ga), .i_gp_b_bit(gb), .o_baud_clk_out_n(baud_n), .o_rx_clk16(rxc),
        .o_rx_data(rxd), .o_tx(tx), .o_bus_drive_disable_n(bus_drive_disable_n_n), .o_pc_decode_en(pce),
        .o_bus_sep(sep), .o_bus_comb(comb), .o_infrared_mode(irm), .o_core_rst_b(crst),
        .o_gp_out_a_n(oa), .o_gp_out_b_n(ob));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_crst;
        for (int n = 0; crst !== 1'b1; n++) begin
            if (n > 30) begin
                errors++;
                $display("FAIL %0t core reset stuck", $time);
                results();
            end
            tick(1);
        end
    endtask
    task automatic t_modes;
        int tog;
        logic prev;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            bsel <= i[1];
            rpin <= i[1];
            pcn <= i[0];
            ppd <= (i == 0);
            tick(8);
            wait_crst();
            tick(2);
            chk(pce, i == 0);
            chk(sep, i == 1);
            chk(comb, i[1]);
            if (i == 0) chk(baud_n, 1'b0);
            if (i < 2) begin
                tog = 0;
                prev = rxc;
                repeat (32) begin
                    tick(1);
                    if (rxc !== prev) tog++;
                    prev = rxc;
                end
                // Divisor 16 toggles the 16x clock every 8 cycles
                if (i == 0) chk(tog == 32 / (16 / 2), 1'b1);
                else chk(tog == 32 / (16 / 2), 1'b1);
            end
        end
        $display("modes done");
    endtask
    task automatic t_read;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            bsel <= m[0];
            rpin <= m[0];
            pcn <= 1;
            tick(8);
            wait_crst();
            @(posedge clk);
            go <= 1;
            @(posedge clk);
            go <= 0;
            tick(5);
            chk(bus_drive_disable_n_n, 1'b0);
            tick(8);
            chk(bus_drive_disable_n_n, 1'b1);
        end
        $display("read done");
    endtask
    task automatic t_ir;
        @(posedge clk);
        irs <= 1;
        rpin <= 0;
        tick(6);
        chk(crst, 1'b0);
        chk(tx, 1'b0);
        chk(rxd, 1'b0);
        @(posedge clk);
        rpin <= 1;
        wait_crst();
        tick(1);
        chk(irm, 1'b1);
        chk(tx, 1'b0);
        @(posedge clk);
        irs <= 0;
        mwr <= 1;
        @(posedge clk);
        mwr <= 0;
        ga <= 1;
        tick(4);
        chk(irm, 1'b0);
        chk(tx, 1'b1);
        chk(oa, 1'b0);
        chk(ob, 1'b1);
        @(posedge clk);
        modem_control_reg <= 8'h40;
        mwr <= 1;
        @(posedge clk);
        mwr <= 0;
        tick(4);
        chk(irm, 1'b1);
        chk(tx, 1'b0);
        $display("infrared done");
    endtask
    initial begin
        {rst_b, bsel, pcn, rpin, rx} = 5'h0f;
        {irs, go, ppd, txa, mwr, ga, gb} = 7'h00;
        div = 16'h0010;
        modem_control_reg = 8'h00;
        tick(6);
        chk(tx, 1'b1);
        chk(bus_drive_disable_n_n, 1'b1);
        chk(oa, 1'b1);
        @(posedge clk);
        rst_b <= 1;
        t_modes();
        t_read();
        t_ir();
        results();
    end
endmodule
